// [pdp_pkg.sv]
// constants and types shared by the pulse-division modulator
package pdp_pkg;

    // =========================================================
    // register map: printed offsets are word indices
    localparam int unsigned IDX_W        = 16;
    localparam int unsigned ADDR_LSB     = 2;
    localparam int unsigned ADDR_TOP     = IDX_W + ADDR_LSB;
    localparam logic [15:0] IDX_CLK_SEL  = 16'hFFD0;
    localparam logic [15:0] IDX_DUTY_UP  = 16'hFFD1;
    localparam logic [15:0] IDX_DUTY_LO  = 16'hFFD2;
    localparam logic [15:0] IDX_CLK_STOP = 16'hFFFB;

    // =========================================================
    // reset and read-back values
    localparam logic [7:0]  CLK_SEL_RST  = 8'hFC;
    localparam logic [7:0]  DUTY_UP_RST  = 8'hC0;
    localparam logic [7:0]  DUTY_LO_RST  = 8'h00;
    localparam logic [7:0]  CLK_STOP_RST = 8'hFF;
    localparam logic [7:0]  READ_ONES    = 8'hFF;
    localparam logic [3:0]  STOP_RSVD    = 4'hF;
    localparam logic [23:0] RDATA_PAD    = 24'h000000;
    localparam logic [31:0] RDATA_NONE   = 32'h00000000;

    // =========================================================
    // field layout
    localparam int unsigned CS_W         = 2;
    localparam int unsigned DUTY_W       = 14;
    localparam int unsigned DUTY_HI_W    = 6;
    localparam int unsigned DUTY_LO_W    = 8;
    localparam int unsigned STOP_W       = 4;
    localparam int unsigned STANDBY_BIT  = 1;
    localparam int unsigned HTRANS_BIT   = 1;

    // =========================================================
    // generator geometry: 64 pulses of 256 steps each
    localparam int unsigned PULSE_IDX_W  = 6;
    localparam int unsigned PULSE_POS_W  = 8;
    localparam int unsigned STEP_W       = PULSE_IDX_W + PULSE_POS_W;
    localparam int unsigned WIDTH_W      = PULSE_POS_W + 2;
    localparam int unsigned DIV_W        = 3;
    localparam logic [9:0]  BASE_ADD     = 10'h001;

    // =========================================================
    // bus data-phase tracker
    typedef enum logic [2:0] {
        PH_IDLE  = 3'b001,
        PH_WRITE = 3'b010,
        PH_READ  = 3'b100
    } pdp_phase_t;

endpackage

// [pdp_pwm.sv]
// pulse-division pwm with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none

module pdp_pwm (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // ahb-lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata,
    // system power state and pin routing
    input  wire logic        i_low_power_hold,
    input  wire logic        i_pin_assign,
    // modulator pin
    output logic             o_pwm_out,
    output logic             o_pwm_oe
);

    // =========================================================
    // decoding helpers

    localparam int unsigned ADDR_LSB_T = pdp_pkg::ADDR_LSB;
    localparam int unsigned ADDR_TOP_T = pdp_pkg::ADDR_TOP;

    function automatic logic addr_hit(input logic [31:0] a,
                                      input logic [15:0] idx);
        addr_hit = (a[ADDR_LSB_T-1:0] == '0)
                 && (a[31:ADDR_TOP_T] == '0)
                 && (a[ADDR_TOP_T-1:ADDR_LSB_T] == idx);
    endfunction

    // steps per generator step: 1, 2, 4 or 8 system clocks
    function automatic logic [pdp_pkg::DIV_W-1:0] div_last(
        input logic [pdp_pkg::CS_W-1:0] cs);
        logic [pdp_pkg::DIV_W:0] n;
        n = (pdp_pkg::DIV_W+1)'(1) << cs;
        div_last = pdp_pkg::DIV_W'(n - (pdp_pkg::DIV_W+1)'(1));
    endfunction

    // =========================================================
    // state

    pdp_pkg::pdp_phase_t               phase_ff;
    pdp_pkg::pdp_phase_t               nxt_phase;
    logic [15:0]                       dp_idx_ff;
    logic [pdp_pkg::CS_W-1:0]          cs_ff;
    logic [pdp_pkg::DUTY_HI_W-1:0]     duty_up_ff;
    logic [pdp_pkg::DUTY_LO_W-1:0]     duty_lo_ff;
    logic [pdp_pkg::STOP_W-1:0]        stop_ff;
    logic [pdp_pkg::DUTY_W-1:0]        pend_duty_ff;
    logic                              pend_ff;
    logic [pdp_pkg::DUTY_W-1:0]        act_duty_ff;
    logic [pdp_pkg::DIV_W-1:0]         div_ff;
    logic [pdp_pkg::STEP_W-1:0]        step_ff;
    logic                              pwm_ff;
    logic                              oe_ff;
    logic [31:0]                       rdata_ff;

    logic                              addr_valid;
    logic [15:0]                       addr_idx;
    logic                              running;
    logic                              step_en;
    logic                              period_end;
    logic                              wr_clk_sel;
    logic                              wr_duty_up;
    logic                              wr_duty_lo;
    logic                              wr_stop;
    logic [7:0]                        rd_byte;
    logic [pdp_pkg::STOP_W-1:0]        stop_view;
    logic                              nxt_pwm;
    logic                              nxt_oe;
    logic                              out_ff;

    // =========================================================
    // ahb address phase

    assign addr_valid = i_hsel && i_hready && i_htrans[pdp_pkg::HTRANS_BIT];

    always_comb begin
        addr_idx = 16'h0000;
        if (addr_hit(i_haddr, pdp_pkg::IDX_CLK_SEL)) begin
            addr_idx = pdp_pkg::IDX_CLK_SEL;
        end else if (addr_hit(i_haddr, pdp_pkg::IDX_DUTY_UP)) begin
            addr_idx = pdp_pkg::IDX_DUTY_UP;
        end else if (addr_hit(i_haddr, pdp_pkg::IDX_DUTY_LO)) begin
            addr_idx = pdp_pkg::IDX_DUTY_LO;
        end else if (addr_hit(i_haddr, pdp_pkg::IDX_CLK_STOP)) begin
            addr_idx = pdp_pkg::IDX_CLK_STOP;
        end
    end

    always_comb begin
        nxt_phase = pdp_pkg::PH_IDLE;
        case (phase_ff)
            pdp_pkg::PH_IDLE,
            pdp_pkg::PH_WRITE,
            pdp_pkg::PH_READ: begin
                if (addr_valid) begin
                    nxt_phase = i_hwrite ? pdp_pkg::PH_WRITE : pdp_pkg::PH_READ;
                end
            end
            default: nxt_phase = pdp_pkg::PH_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            phase_ff  <= pdp_pkg::PH_IDLE;
            dp_idx_ff <= 16'h0000;
        end else begin
            phase_ff  <= nxt_phase;
            dp_idx_ff <= addr_idx;
        end
    end

    // a read taken while a clock stop write is in its data phase must see
    // the new bits, otherwise back-to-back write then read returns stale data
    always_comb begin
        stop_view = stop_ff;
        if (wr_stop) begin
            stop_view = i_hwdata[pdp_pkg::STOP_W-1:0];
        end
    end

    // every read answer is prepared in the address phase
    always_comb begin
        rd_byte = pdp_pkg::READ_ONES;
        if (addr_idx == pdp_pkg::IDX_CLK_STOP) begin
            rd_byte = {pdp_pkg::STOP_RSVD, stop_view};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rdata_ff <= pdp_pkg::RDATA_NONE;
        end else if (addr_valid && !i_hwrite) begin
            if (addr_idx == 16'h0000) begin
                rdata_ff <= pdp_pkg::RDATA_NONE;
            end else begin
                rdata_ff <= {pdp_pkg::RDATA_PAD, rd_byte};
            end
        end
    end

    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_hrdata    = rdata_ff;

    // =========================================================
    // register writes (data phase)

    // module standby and system hold freeze the modulator registers
    assign running    = stop_ff[pdp_pkg::STANDBY_BIT] && !i_low_power_hold;

    assign wr_clk_sel = (phase_ff == pdp_pkg::PH_WRITE)
                     && (dp_idx_ff == pdp_pkg::IDX_CLK_SEL) && running;
    assign wr_duty_up = (phase_ff == pdp_pkg::PH_WRITE)
                     && (dp_idx_ff == pdp_pkg::IDX_DUTY_UP) && running;
    assign wr_duty_lo = (phase_ff == pdp_pkg::PH_WRITE)
                     && (dp_idx_ff == pdp_pkg::IDX_DUTY_LO) && running;
    assign wr_stop    = (phase_ff == pdp_pkg::PH_WRITE)
                     && (dp_idx_ff == pdp_pkg::IDX_CLK_STOP)
                     && !i_low_power_hold;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cs_ff <= pdp_pkg::CLK_SEL_RST[pdp_pkg::CS_W-1:0];
        end else if (wr_clk_sel) begin
            cs_ff <= i_hwdata[pdp_pkg::CS_W-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            duty_up_ff <= pdp_pkg::DUTY_UP_RST[pdp_pkg::DUTY_HI_W-1:0];
            duty_lo_ff <= pdp_pkg::DUTY_LO_RST;
        end else begin
            if (wr_duty_up) begin
                duty_up_ff <= i_hwdata[pdp_pkg::DUTY_HI_W-1:0];
            end
            if (wr_duty_lo) begin
                duty_lo_ff <= i_hwdata[pdp_pkg::DUTY_LO_W-1:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            stop_ff <= pdp_pkg::CLK_STOP_RST[pdp_pkg::STOP_W-1:0];
        end else if (wr_stop) begin
            stop_ff <= i_hwdata[pdp_pkg::STOP_W-1:0];
        end
    end

    // =========================================================
    // duty latch: the upper write captures both bytes at once
    // lower byte must already be in place, hence lower-then-upper order

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pend_duty_ff <= '0;
            pend_ff      <= 1'b0;
        end else if (wr_duty_up) begin
            pend_duty_ff <= {i_hwdata[pdp_pkg::DUTY_HI_W-1:0], duty_lo_ff};
            pend_ff      <= 1'b1;
        end else if (period_end) begin
            pend_ff      <= 1'b0;
        end
    end

    // new data only starts at a period boundary so no period is torn
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            act_duty_ff <= '0;
        end else if (period_end && pend_ff) begin
            act_duty_ff <= pend_duty_ff;
        end
    end

    // =========================================================
    // step timebase: one step is 1, 2, 4 or 8 system clocks, set by the clock select

    assign step_en    = running && (div_ff == div_last(cs_ff));
    assign period_end = step_en && (step_ff == '1);

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            div_ff <= '0;
        end else if (running) begin
            if (step_en || div_ff > div_last(cs_ff)) begin
                div_ff <= '0;
            end else begin
                div_ff <= div_ff + pdp_pkg::DIV_W'(1);
            end
        end
    end

    // 16384 steps per period: 64 pulses of 256 steps
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            step_ff <= '0;
        end else if (step_en) begin
            step_ff <= step_ff + pdp_pkg::STEP_W'(1);
        end
    end

    // =========================================================
    // pulse shaping

    logic [pdp_pkg::PULSE_IDX_W-1:0] pulse_idx;
    logic [pdp_pkg::PULSE_IDX_W-1:0] pulse_rev;
    logic [pdp_pkg::PULSE_POS_W-1:0] pulse_pos;
    logic                            extra;
    logic [pdp_pkg::WIDTH_W-1:0]     pulse_width;

    assign pulse_idx = step_ff[pdp_pkg::STEP_W-1:pdp_pkg::PULSE_POS_W];
    assign pulse_pos = step_ff[pdp_pkg::PULSE_POS_W-1:0];

    // bit reversal orders pulses so extra steps land evenly
    genvar g;
    generate
        for (g = 0; g < pdp_pkg::PULSE_IDX_W; g++) begin : g_rev
            assign pulse_rev[g] = pulse_idx[pdp_pkg::PULSE_IDX_W-1-g];
        end
    endgenerate

    // exactly duty[5:0] of the 64 pulses get one extra step
    assign extra = pulse_rev < act_duty_ff[pdp_pkg::DUTY_HI_W-1:0];

    // base + 1 per pulse supplies the +64 term of the high time
    assign pulse_width = pdp_pkg::WIDTH_W'(act_duty_ff[pdp_pkg::DUTY_W-1:pdp_pkg::DUTY_HI_W])
                       + pdp_pkg::BASE_ADD
                       + pdp_pkg::WIDTH_W'(extra);

    // next pin values, shared by the internal flops and the pin flop
    always_comb begin
        nxt_pwm = pwm_ff;
        if (!stop_ff[pdp_pkg::STANDBY_BIT]) begin
            nxt_pwm = 1'b0;
        end else if (running) begin
            nxt_pwm = pdp_pkg::WIDTH_W'(pulse_pos) < pulse_width;
        end
    end

    assign nxt_oe = i_pin_assign && stop_ff[pdp_pkg::STANDBY_BIT];

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pwm_ff <= 1'b0;
        end else begin
            pwm_ff <= nxt_pwm;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            oe_ff <= 1'b0;
        end else begin
            oe_ff <= nxt_oe;
        end
    end

    // the pin gets a flop of its own so no gate sits between flop and pad
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            out_ff <= 1'b0;
        end else begin
            out_ff <= nxt_pwm && nxt_oe;
        end
    end

    assign o_pwm_out = out_ff;
    assign o_pwm_oe  = oe_ff;

    // i_hsize is accepted for bus compliance; only word access is used
    logic unused_ok;
    assign unused_ok = ^i_hsize;

endmodule

`default_nettype wire

// [pdp_pwm_asserts.sv]
// port-level assertion checker for the pulse-division modulator
`timescale 1ns/1ps
`default_nettype none
module pdp_pwm_asserts (
    // clock, reset and bus
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic        i_hready,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    input wire logic [31:0] o_hrdata,
    // power state and pin
    input wire logic        i_low_power_hold,
    input wire logic        i_pin_assign,
    input wire logic        o_pwm_out,
    input wire logic        o_pwm_oe
);
    logic [13:0] low_run_ff;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // ==========
    // helpers
    sequence s_rd(logic [15:0] idx);
        i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_haddr == {14'h0000, idx, 2'h0};
    endsequence

    // even a zero duty gives one high step per pulse, so long low runs mean a stall
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || !o_pwm_oe || i_low_power_hold || o_pwm_out) begin
            low_run_ff <= 14'h0000;
        end else begin
            low_run_ff <= low_run_ff + 14'h0001;
        end
    end

    // ==========
    // properties
    a_bus_okay:
        assert property (o_hreadyout && !o_hresp) else $error("bus answer not okay");
    a_sel_reads_ones:
        assert property (s_rd(pdp_pkg::IDX_CLK_SEL) |=> o_hrdata == 32'h000000FF)
        else $error("clock select read wrong");
    a_duty_reads_ones:
        assert property ((s_rd(pdp_pkg::IDX_DUTY_UP) or s_rd(pdp_pkg::IDX_DUTY_LO))
            |=> o_hrdata == 32'h000000FF) else $error("duty read wrong");
    a_stop_top_ones:
        assert property (s_rd(pdp_pkg::IDX_CLK_STOP) |=> o_hrdata[31:4] == 28'h000000F)
        else $error("clock stop read wrong");
    a_rdata_stands:
        assert property (!(i_hsel && i_hready && i_htrans[1] && !i_hwrite)
            |=> $stable(o_hrdata)) else $error("read data moved");
    a_oe_needs_pin:
        assert property (!i_pin_assign |=> !o_pwm_oe) else $error("pin driven unassigned");
    a_hold_freezes:
        assert property (i_low_power_hold |=> $stable(o_pwm_out)) else $error("output moved in hold");
    a_pulse_keeps:
        assert property (low_run_ff <= 14'h2000) else $error("pulse train stalled");
endmodule

bind pdp_pwm pdp_pwm_asserts u_pdp_pwm_asserts (
    .i_clk, .i_reset_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready, .o_hreadyout,
    .o_hresp, .o_hrdata, .i_low_power_hold, .i_pin_assign, .o_pwm_out, .o_pwm_oe
);
`default_nettype wire

// [pdp_lpf.sv]
// low-pass filter model that integrates the high time on the output pin
`timescale 1ns/1ps
`default_nettype none
module pdp_lpf (
    // pin side
    input  wire logic        i_clk,
    input  wire logic        i_pwm_out,
    input  wire logic        i_pwm_oe,
    // integrated charge
    output logic [31:0]      o_charge
);
    logic        pin;
    logic [31:0] charge_ff = 32'h00000000;

    // the load resistor pulls an undriven pin low
    assign pin      = i_pwm_oe ? i_pwm_out : 1'b0;
    assign o_charge = charge_ff;
    always @(posedge i_clk) begin
        charge_ff <= charge_ff + {31'h00000000, pin};
    end
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the pulse-division modulator
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        i_clk;
    logic        i_reset_n;
    logic        i_hsel;
    logic [31:0] i_haddr;
    logic [1:0]  i_htrans;
    logic        i_hwrite;
    logic [31:0] i_hwdata;
    logic        i_low_power_hold;
    logic        i_pin_assign;
    logic        o_hreadyout;
    logic        o_hresp;
    logic [31:0] o_hrdata;
    logic        o_pwm_out;
    logic        o_pwm_oe;
    logic [31:0] charge;
    logic [31:0] got;
    logic [31:0] mark;
    logic [31:0] exp_q[$];
    string       nm_q[$];
    int          failures;
    int          comparisons;
    int          seed;
    int          rnd;
    logic [13:0] duty;
    event        got_ev;

    pdp_pwm u_pdp_pwm (
        .i_clk, .i_reset_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2),
        .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hresp, .o_hrdata,
        .i_low_power_hold, .i_pin_assign, .o_pwm_out, .o_pwm_oe
    );
    pdp_lpf u_pdp_lpf (.i_clk, .i_pwm_out(o_pwm_out), .i_pwm_oe(o_pwm_oe), .o_charge(charge));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // ==========
    // bus master and measurement
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        @(posedge i_clk);
        i_hsel   <= 1'b1;
        i_htrans <= 2'h2;
        i_hwrite <= wr;
        i_haddr  <= {14'h0000, idx, 2'h0};
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        i_hsel   <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        got = o_hrdata;
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input string nm);
        exp_q.push_back(exp);
        nm_q.push_back(nm);
        bus(1'b0, idx, 32'h00000000);
        ->got_ev;
    endtask

    // settles first so a latch or divider change has landed before counting
    task automatic meas(input int n, input logic [31:0] exp, input string nm);
        exp_q.push_back(exp);
        nm_q.push_back(nm);
        repeat (n + 8) @(negedge i_clk);
        mark = charge;
        repeat (n) @(negedge i_clk);
        got = charge - mark;
        ->got_ev;
    endtask

    always @(got_ev) begin
        comparisons++;
        if (got !== exp_q[0]) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm_q[0], exp_q[0], got);
        end
        exp_q.delete(0);
        nm_q.delete(0);
    end

    task automatic results;
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge i_clk);
        failures++;
        results();
    end

    // ==========
    // scenarios
    initial begin
        seed             = 50;
        failures         = 0;
        comparisons      = 0;
        i_reset_n        = 1'b0;
        i_hsel           = 1'b0;
        i_haddr          = 32'h00000000;
        i_htrans         = 2'h0;
        i_hwrite         = 1'b0;
        i_hwdata         = 32'h00000000;
        i_low_power_hold = 1'b0;
        i_pin_assign     = 1'b1;
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(pdp_pkg::IDX_CLK_SEL, 32'h000000FF, "clk_sel");
        rd(pdp_pkg::IDX_DUTY_UP, 32'h000000FF, "duty_up");
        rd(pdp_pkg::IDX_DUTY_LO, 32'h000000FF, "duty_lo");
        rd(pdp_pkg::IDX_CLK_STOP, 32'h000000FF, "clk_stop");
        rd(16'h0000, 32'h00000000, "unmapped");
        bus(1'b1, pdp_pkg::IDX_CLK_SEL, 32'h00000000);
        meas(256, 32'h00000001, "reset_pulse");
        rnd  = $random(seed);
        duty = rnd[13:0] & 14'h3EFF;
        bus(1'b1, pdp_pkg::IDX_DUTY_LO, {rnd[31:8], duty[7:0]});
        bus(1'b1, pdp_pkg::IDX_DUTY_UP, {rnd[31:6], duty[13:8]});
        meas(16384, {18'h00000, duty} + 32'h00000040, "duty_total");
        bus(1'b1, pdp_pkg::IDX_DUTY_LO, 32'h000000C0);
        bus(1'b1, pdp_pkg::IDX_DUTY_UP, 32'h00000002);
        repeat (16392) @(posedge i_clk);
        for (int cs = 0; cs < 4; cs++) begin
            bus(1'b1, pdp_pkg::IDX_CLK_SEL, 32'hFFFFFFFC | cs);
            meas(256 << cs, 32'(12 << cs), "pulse_high");
        end
        rd(pdp_pkg::IDX_CLK_SEL, 32'h000000FF, "clk_sel");
        bus(1'b1, pdp_pkg::IDX_CLK_STOP, 32'h000000F5);
        rd(pdp_pkg::IDX_CLK_STOP, 32'h000000F5, "clk_stop");
        meas(512, 32'h00000000, "standby_high");
        bus(1'b1, pdp_pkg::IDX_CLK_SEL, 32'h00000000);
        bus(1'b1, pdp_pkg::IDX_CLK_STOP, 32'h000000FF);
        meas(2048, 32'h00000060, "resume_high");
        @(posedge i_clk);
        i_low_power_hold <= 1'b1;
        bus(1'b1, pdp_pkg::IDX_CLK_STOP, 32'h00000000);
        rd(pdp_pkg::IDX_CLK_STOP, 32'h000000FF, "held_stop");
        i_low_power_hold <= 1'b0;
        i_pin_assign     <= 1'b0;
        meas(2048, 32'h00000000, "unassigned");
        @(posedge i_clk);
        results();
    end
endmodule
`default_nettype wire
